// [hw/axis_param_pkg.sv]
// Constants shared by the axis parameter block and its encoder front end.
// Assumes one 40 MHz clock and register access by word index times four.
package axis_param_pkg;
    localparam int ADDR_W = 10;
    localparam int MODE_W = 9;

    // Register indices; byte address is four times the index.
    localparam logic [7:0] IDX_LATCH_ACT = 8'hc6;
    localparam logic [7:0] IDX_LATCH_ENC = 8'hc7;
    localparam logic [7:0] IDX_ENC_MODE = 8'hc9;
    localparam logic [7:0] IDX_FULLSTEPS = 8'hca;
    localparam logic [7:0] IDX_IDLE_COIL = 8'hcc;
    localparam logic [7:0] IDX_LOAD = 8'hce;
    localparam logic [7:0] IDX_EXT_FAULT = 8'hcf;
    localparam logic [7:0] IDX_DRV_STATUS = 8'hd0;
    localparam logic [7:0] IDX_ENC_COUNT = 8'hd1;
    localparam logic [7:0] IDX_ENC_RES = 8'hd2;
    localparam logic [7:0] IDX_MAX_DEV = 8'hd4;
    localparam logic [7:0] IDX_GROUP = 8'hd5;
    localparam logic [7:0] IDX_PWR_DELAY = 8'hd6;
    localparam logic [7:0] IDX_DIR_INV = 8'hfb;
    localparam logic [7:0] IDX_UNIT = 8'hff;

    // Encoder mode bit positions.
    localparam int MODE_A_LVL = 0;
    localparam int MODE_B_LVL = 1;
    localparam int MODE_N_LVL = 2;
    localparam int MODE_IGNORE_AB = 3;
    localparam int MODE_EVERY = 4;
    localparam int MODE_NEXT = 5;
    localparam int MODE_CLR_ENC = 8;

    // Extended fault flag positions.
    localparam int EXT_STALL = 0;
    localparam int EXT_DEVIATION = 1;

    // Reset values.
    localparam logic [15:0] FULLSTEPS_RST = 16'h00c8;
    localparam logic [15:0] PWR_DELAY_RST = 16'h00c8;
    localparam logic UNIT_RST = 1'b1;

    // Timing.
    localparam int CLK_HZ = 40_000_000;
    localparam int PWR_UNIT_MS = 10;
    localparam int PWR_UNIT_CYCLES = CLK_HZ / 1000 * PWR_UNIT_MS;
    localparam int STANDSTILL_CYCLES = 1 << 20;

    typedef enum logic [2:0] {
        ROTATE_LEFT_CMD = 3'h0,
        ROTATE_RIGHT_CMD = 3'h1,
        MOTOR_HALT_CMD = 3'h2,
        MOVE_TO_POSITION_CMD = 3'h3,
        REFERENCE_SEARCH_CMD = 3'h4
    } motion_cmd_t;

    typedef enum logic {
        ARM_IDLE = 1'b0,
        ARM_WAIT = 1'b1
    } arm_state_t;
endpackage

// [hw/enc_if.sv]
// Carrier between the axis block and its encoder front end.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface enc_if;
    logic [8:0] mode;
    logic countUp;
    logic countDown;
    logic indexEvent;
    modport decoder(input mode, output countUp, output countDown, output indexEvent);
    modport user(output mode, input countUp, input countDown, input indexEvent);
endinterface

// [hw/quad_index_decoder.sv]
// Quadrature decoder and index qualifier for one encoder.
// Assumes encoder inputs are already synchronous to clk.
`timescale 1ns/1ps
module quad_index_decoder
    import axis_param_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic encA,
    input wire logic encB,
    input wire logic encN,
    enc_if.decoder enc
);
    typedef struct packed {
        logic aPrev;
        logic bPrev;
        logic qualPrev;
        logic up;
        logic down;
        logic index;
    } dec_state_t;

    dec_state_t s;
    dec_state_t n;
    logic qual;

    // An index counts only at its active level and, unless ignored, with A and B as set.
    always_comb begin
        qual = (encN == enc.mode[MODE_N_LVL]) &&
            (enc.mode[MODE_IGNORE_AB] ||
            (encA == enc.mode[MODE_A_LVL] && encB == enc.mode[MODE_B_LVL]));
        n = s;
        n.aPrev = encA;
        n.bPrev = encB;
        n.qualPrev = qual;
        n.index = qual && !s.qualPrev;
        n.up = 1'b0;
        n.down = 1'b0;
        if ((encA ^ s.aPrev) != (encB ^ s.bPrev)) begin
            n.up = encA ^ s.bPrev;
            n.down = !(encA ^ s.bPrev);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign enc.countUp = s.up;
    assign enc.countDown = s.down;
    assign enc.indexEvent = s.index;

    sequence qual_rise;
        !s.qualPrev ##1 s.qualPrev;
    endsequence

    property index_needs_qual;
        @(posedge clk) disable iff (srst)
        enc.indexEvent |-> s.qualPrev && $past(!s.qualPrev);
    endproperty

    property rise_gives_index;
        @(posedge clk) disable iff (srst)
        qual_rise |-> enc.indexEvent;
    endproperty

    AST_INDEX_QUALIFIED: assert property (index_needs_qual)
        else $error("Index event without a qualified index level.");
    AST_INDEX_ON_RISE: assert property (rise_gives_index)
        else $error("Qualified index level rose without an index event.");
endmodule

// [hw/axis_param_block.sv]
// Parameter bank, index latching and fault status for one stepper axis.
// Assumes synchronous inputs and a master that never overlaps strobes.
// How it works
// - Qualified index copies actual position into latched actual position.
// - Qualified index copies encoder counter into latched encoder position.
// - Mode bits 0,1 set required A,B levels; bit 2 sets index level.
// - Mode bit 3 ignores A and B levels for index qualification.
// - Mode bit 4 latches or clears on every qualified index.
// - Mode bit 5 latches or clears only on the next qualified index.
// - Mode bit 8 also clears the encoder counter on an index.
// - Full steps per revolution is 16-bit writable, resets to 200.
// - With zero standby current, the idle coil mode drives the coils.
// - The 10-bit load measurement reads back as read-only.
// - Extended flags: value 1 stall, value 2 deviation.
// - Extended flags clear on read or when a motion command executes.
// - Status bits 0-2: stall, overtemperature shutdown, temperature pre-warning.
// - Status bits 3,4 show short to ground on coil A, B.
// - Status bits 5,6 show open load when no chop in a polarity period.
// - Status bit 7 shows no step pulse during the last 2^20 cycles.
// - Encoder counts per revolution is a 16-bit writable setting.
// - Motor halts when position deviation exceeds the nonzero maximum.
// - Commands from an axis with the same nonzero group are applied here, unless a local command arrives in the same cycle and wins.
// - After standstill for delay times 10 ms, current drops to standby.
// - Direction invert set flips the motor direction.
// - Unit select picks internal or pulse units, resets to 1.
`timescale 1ns/1ps
module axis_param_block
    import axis_param_pkg::*;
#(
    parameter int STANDSTILL_LIMIT = STANDSTILL_CYCLES,
    parameter int PWR_UNIT_LIMIT = PWR_UNIT_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [axis_param_pkg::ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    input wire logic encA,
    input wire logic encB,
    input wire logic encN,
    input wire logic [31:0] actualPos,
    input wire logic [9:0] loadValue,
    input wire logic stallDetect,
    input wire logic overTemp,
    input wire logic tempWarn,
    input wire logic shortA,
    input wire logic shortB,
    input wire logic coilPolA,
    input wire logic coilPolB,
    input wire logic chopA,
    input wire logic chopB,
    input wire logic stepPulse,
    input wire logic dirIn,
    input wire logic standbyZero,
    input wire logic localCmdValid,
    input wire axis_param_pkg::motion_cmd_t localCmd,
    input wire logic peerCmdValid,
    input wire logic [7:0] peerCmdGroup,
    input wire axis_param_pkg::motion_cmd_t peerCmd,
    output logic applyValid,
    output axis_param_pkg::motion_cmd_t applyCmd,
    output logic groupOutValid,
    output logic [7:0] groupOutIndex,
    output axis_param_pkg::motion_cmd_t groupOutCmd,
    output logic motorHalt,
    output logic currentReduce,
    output logic [1:0] coilMode,
    output logic dirOut,
    output logic unitSelect,
    output logic [15:0] fullSteps,
    output logic [15:0] encCountsPerRev
);
    import axis_param_pkg::*;

    typedef struct packed {
        logic [31:0] latchAct;
        logic [31:0] latchEnc;
        logic [8:0] mode;
        arm_state_t arm;
        logic [15:0] fullsteps;
        logic [1:0] idleCoil;
        logic [1:0] extFlags;
        logic [31:0] encCount;
        logic [15:0] encRes;
        logic [31:0] maxDev;
        logic [7:0] group;
        logic [15:0] pwrDelay;
        logic dirInv;
        logic unitSel;
        logic polA;
        logic polB;
        logic sawChopA;
        logic sawChopB;
        logic openA;
        logic openB;
        logic [31:0] stillCnt;
        logic standstill;
        logic [31:0] tickCnt;
        logic [15:0] unitCnt;
        logic reduced;
        logic [31:0] rdData;
        logic applyValid;
        motion_cmd_t applyCmd;
        logic groupValid;
        motion_cmd_t groupCmd;
        logic halt;
        logic [1:0] coilMode;
        logic dirOut;
    } axis_state_t;

    axis_state_t s;
    axis_state_t n;
    enc_if enc();
    logic fire;
    logic peerMatch;
    logic signed [32:0] posDiff;
    logic [32:0] posDist;
    logic devHit;
    logic [7:0] status;

    function automatic logic [ADDR_W-1:0] adr(input logic [7:0] idx);
        return {idx, 2'b00};
    endfunction

    quad_index_decoder u_quad_index_decoder (
        .clk(clk),
        .srst(srst),
        .encA(encA),
        .encB(encB),
        .encN(encN),
        .enc(enc)
    );

    assign enc.mode = s.mode;

    always_comb begin
        fire = enc.indexEvent && (s.mode[MODE_EVERY] || s.arm == ARM_WAIT);
        peerMatch = peerCmdValid && s.group != 8'h00 && peerCmdGroup == s.group;
        posDiff = $signed({actualPos[31], actualPos}) - $signed({s.encCount[31], s.encCount});
        posDist = posDiff[32] ? 33'(-posDiff) : posDiff;
        devHit = s.maxDev != 32'h0 && posDist > {1'b0, s.maxDev};
        status = {s.standstill, s.openB, s.openA, shortB, shortA,
            tempWarn, overTemp, stallDetect};
        n = s;
        n.rdData = 32'h0;
        n.applyValid = localCmdValid || peerMatch;
        n.applyCmd = localCmdValid ? localCmd : peerCmd;
        n.groupValid = localCmdValid && s.group != 8'h00;
        n.groupCmd = localCmd;
        n.halt = devHit;
        n.dirOut = dirIn ^ s.dirInv;
        n.coilMode = (s.reduced && standbyZero) ? s.idleCoil : 2'b00;

        // Index handling: latch, optional clear, then single-shot disarm.
        if (enc.countUp) begin
            n.encCount = s.encCount + 32'h1;
        end else if (enc.countDown) begin
            n.encCount = s.encCount - 32'h1;
        end
        if (fire) begin
            n.latchAct = actualPos;
            n.latchEnc = s.encCount;
            if (s.mode[MODE_CLR_ENC]) begin
                n.encCount = 32'h0;
            end
            n.arm = ARM_IDLE;
        end

        // Open load: a polarity period with no chop event reports open.
        if (coilPolA != s.polA) begin
            n.openA = !s.sawChopA;
            n.sawChopA = chopA;
        end else if (chopA) begin
            n.sawChopA = 1'b1;
        end
        if (coilPolB != s.polB) begin
            n.openB = !s.sawChopB;
            n.sawChopB = chopB;
        end else if (chopB) begin
            n.sawChopB = 1'b1;
        end
        n.polA = coilPolA;
        n.polB = coilPolB;

        // Standstill detection and power-down delay in 10 ms units.
        if (stepPulse) begin
            n.stillCnt = 32'h0;
            n.standstill = 1'b0;
        end else if (s.stillCnt < 32'(STANDSTILL_LIMIT - 1)) begin
            n.stillCnt = s.stillCnt + 32'h1;
        end else begin
            n.standstill = 1'b1;
        end
        if (!s.standstill) begin
            n.tickCnt = 32'h0;
            n.unitCnt = 16'h0;
            n.reduced = 1'b0;
        end else if (s.unitCnt >= s.pwrDelay) begin
            n.reduced = 1'b1;
        end else if (s.tickCnt == 32'(PWR_UNIT_LIMIT - 1)) begin
            n.tickCnt = 32'h0;
            n.unitCnt = s.unitCnt + 16'h1;
        end else begin
            n.tickCnt = s.tickCnt + 32'h1;
        end

        // Extended flags: clears first so a new fault in the same cycle wins.
        if ((regRd && regAddr == adr(IDX_EXT_FAULT)) || s.applyValid) begin
            n.extFlags = 2'b00;
        end
        if (stallDetect) begin
            n.extFlags[EXT_STALL] = 1'b1;
        end
        if (devHit) begin
            n.extFlags[EXT_DEVIATION] = 1'b1;
        end

        if (regRd) begin
            case (regAddr)
                adr(IDX_LATCH_ACT): n.rdData = s.latchAct;
                adr(IDX_LATCH_ENC): n.rdData = s.latchEnc;
                adr(IDX_ENC_MODE): n.rdData = {23'h0, s.mode};
                adr(IDX_FULLSTEPS): n.rdData = {16'h0, s.fullsteps};
                adr(IDX_IDLE_COIL): n.rdData = {30'h0, s.idleCoil};
                adr(IDX_LOAD): n.rdData = {22'h0, loadValue};
                adr(IDX_EXT_FAULT): n.rdData = {30'h0, s.extFlags};
                adr(IDX_DRV_STATUS): n.rdData = {24'h0, status};
                adr(IDX_ENC_COUNT): n.rdData = s.encCount;
                adr(IDX_ENC_RES): n.rdData = {16'h0, s.encRes};
                adr(IDX_MAX_DEV): n.rdData = s.maxDev;
                adr(IDX_GROUP): n.rdData = {24'h0, s.group};
                adr(IDX_PWR_DELAY): n.rdData = {16'h0, s.pwrDelay};
                adr(IDX_DIR_INV): n.rdData = {31'h0, s.dirInv};
                adr(IDX_UNIT): n.rdData = {31'h0, s.unitSel};
                default: n.rdData = 32'h0;
            endcase
        end

        if (regWr) begin
            case (regAddr)
                adr(IDX_ENC_MODE): begin
                    n.mode = regWrData[8:0];
                    n.arm = regWrData[MODE_NEXT] ? ARM_WAIT : ARM_IDLE;
                end
                adr(IDX_FULLSTEPS): n.fullsteps = regWrData[15:0];
                adr(IDX_IDLE_COIL): n.idleCoil = regWrData[1:0];
                adr(IDX_ENC_COUNT): n.encCount = regWrData;
                adr(IDX_ENC_RES): n.encRes = regWrData[15:0];
                adr(IDX_MAX_DEV): n.maxDev = regWrData;
                adr(IDX_GROUP): n.group = regWrData[7:0];
                adr(IDX_PWR_DELAY): n.pwrDelay = regWrData[15:0];
                adr(IDX_DIR_INV): n.dirInv = regWrData[0];
                adr(IDX_UNIT): n.unitSel = regWrData[0];
                default: n.mode = n.mode;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
            s.fullsteps <= FULLSTEPS_RST;
            s.pwrDelay <= PWR_DELAY_RST;
            s.unitSel <= UNIT_RST;
        end else begin
            s <= n;
        end
    end

    assign regRdData = s.rdData;
    assign applyValid = s.applyValid;
    assign applyCmd = s.applyCmd;
    assign groupOutValid = s.groupValid;
    assign groupOutIndex = s.group;
    assign groupOutCmd = s.groupCmd;
    assign motorHalt = s.halt;
    assign currentReduce = s.reduced;
    assign coilMode = s.coilMode;
    assign dirOut = s.dirOut;
    assign unitSelect = s.unitSel;
    assign fullSteps = s.fullsteps;
    assign encCountsPerRev = s.encRes;

    logic modeWrite;
    logic encWrite;
    assign modeWrite = regWr && regAddr == adr(IDX_ENC_MODE);
    assign encWrite = regWr && regAddr == adr(IDX_ENC_COUNT);

    sequence fire_seq;
        fire && !encWrite;
    endsequence

    sequence quiet_steps;
        !stepPulse [*8];
    endsequence

    AST_LATCH_ACTUAL: assert property (@(posedge clk) disable iff (srst)
        fire |=> s.latchAct == $past(actualPos))
        else $error("Latched actual position missed the index.");
    AST_LATCH_ENCODER: assert property (@(posedge clk) disable iff (srst)
        fire |=> s.latchEnc == $past(s.encCount))
        else $error("Latched encoder position missed the index.");
    AST_CLEAR_ON_INDEX: assert property (@(posedge clk) disable iff (srst)
        fire_seq and s.mode[MODE_CLR_ENC] |=> s.encCount == 32'h0)
        else $error("Encoder counter not cleared on index.");
    AST_ENC_WRITE: assert property (@(posedge clk) disable iff (srst)
        encWrite |=> s.encCount == $past(regWrData))
        else $error("Encoder count write not loaded.");
    AST_SINGLE_SHOT: assert property (@(posedge clk) disable iff (srst)
        fire && !modeWrite |=> s.arm == ARM_IDLE)
        else $error("Single-shot latch still armed after firing.");
    AST_NO_LATCH_IDLE: assert property (@(posedge clk) disable iff (srst)
        enc.indexEvent && !s.mode[MODE_EVERY] && s.arm == ARM_IDLE |=> $stable(s.latchAct))
        else $error("Latch fired while disarmed.");
    AST_EXT_CLEAR: assert property (@(posedge clk) disable iff (srst)
        regRd && regAddr == adr(IDX_EXT_FAULT) && !stallDetect && !devHit
        |=> s.extFlags == 2'b00 && s.rdData == {30'h0, $past(s.extFlags)})
        else $error("Extended flags not cleared by read.");
    AST_DEV_OFF: assert property (@(posedge clk) disable iff (srst)
        s.maxDev == 32'h0 |=> !s.halt)
        else $error("Deviation halt with check disabled.");
    AST_GROUP_FANOUT: assert property (@(posedge clk) disable iff (srst)
        peerMatch && !localCmdValid |=> s.applyValid && s.applyCmd == $past(peerCmd))
        else $error("Group command not applied.");
    AST_STEP_CLEARS_STILL: assert property (@(posedge clk) disable iff (srst)
        stepPulse ##1 quiet_steps |-> !s.standstill)
        else $error("Standstill reported too soon after a step.");
    AST_FREEWHEEL_GATE: assert property (@(posedge clk) disable iff (srst)
        !standbyZero |=> s.coilMode == 2'b00)
        else $error("Idle coil mode applied with nonzero standby current.");
    AST_REVERSE: assert property (@(posedge clk) disable iff (srst)
        s.dirInv && $stable(s.dirInv) |-> dirOut == !$past(dirIn))
        else $error("Direction not inverted.");
endmodule

// [tb/quad_encoder_model.sv]
// Quadrature encoder with index channel, stepped by bench tasks.
// Assumes the bench calls its tasks from one process right after a clock edge.
`timescale 1ns/1ps
module quad_encoder_model (
    input wire logic clk,
    output logic encA,
    output logic encB,
    output logic encN
);
    initial begin
        encA = 1'b0;
        encB = 1'b0;
        encN = 1'b0;
    end
    // One step upwards; only one channel changes, A leads B.
    task automatic stepUp();
        @(posedge clk);
        if (encA == encB) begin
            encA <= ~encA;
        end else begin
            encB <= ~encB;
        end
    endtask
    // Index pulse, active high, two cycles wide.
    task automatic indexPulse();
        @(posedge clk);
        encN <= 1'b1;
        repeat (2) @(posedge clk);
        encN <= 1'b0;
    endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the axis parameter block.
// Assumes the encoder model and the package are compiled first.
`timescale 1ns/1ps
`define CHK(a, e, m) begin n_compared++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED %0t %s", $time, m); end end
module testbench;
    import axis_param_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [31:0] regWrData = '0;
    logic [31:0] actualPos = '0;
    logic regWr = 1'b0, regRd = 1'b0, stallDetect = 1'b0, overTemp = 1'b0, tempWarn = 1'b0;
    logic shortA = 1'b0, shortB = 1'b0, coilPolA = 1'b0, coilPolB = 1'b0;
    logic chopA = 1'b0, chopB = 1'b0, stepPulse = 1'b0, dirIn = 1'b0, standbyZero = 1'b0;
    logic localCmdValid = 1'b0, peerCmdValid = 1'b0;
    logic [9:0] loadValue = '0;
    logic [7:0] peerCmdGroup = '0;
    motion_cmd_t localCmd = ROTATE_LEFT_CMD, peerCmd = ROTATE_LEFT_CMD;
    logic [31:0] regRdData;
    logic encA, encB, encN, applyValid, groupOutValid, motorHalt, currentReduce;
    logic dirOut, unitSelect;
    motion_cmd_t applyCmd, groupOutCmd;
    logic [7:0] groupOutIndex;
    logic [1:0] coilMode;
    logic [15:0] fullSteps, encCountsPerRev;
    int failures = 0;
    int n_compared = 0;

    always #12.5 clk = ~clk;

    quad_encoder_model u_quad_encoder_model (.clk(clk), .encA(encA), .encB(encB), .encN(encN));

    axis_param_block #(.STANDSTILL_LIMIT(16), .PWR_UNIT_LIMIT(4)) u_axis_param_block (
        .clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .encA(encA), .encB(encB), .encN(encN),
        .actualPos(actualPos), .loadValue(loadValue), .stallDetect(stallDetect),
        .overTemp(overTemp), .tempWarn(tempWarn), .shortA(shortA), .shortB(shortB),
        .coilPolA(coilPolA), .coilPolB(coilPolB), .chopA(chopA), .chopB(chopB),
        .stepPulse(stepPulse), .dirIn(dirIn), .standbyZero(standbyZero),
        .localCmdValid(localCmdValid), .localCmd(localCmd), .peerCmdValid(peerCmdValid),
        .peerCmdGroup(peerCmdGroup), .peerCmd(peerCmd), .applyValid(applyValid),
        .applyCmd(applyCmd), .groupOutValid(groupOutValid), .groupOutIndex(groupOutIndex),
        .groupOutCmd(groupOutCmd), .motorHalt(motorHalt), .currentReduce(currentReduce),
        .coilMode(coilMode), .dirOut(dirOut), .unitSelect(unitSelect),
        .fullSteps(fullSteps), .encCountsPerRev(encCountsPerRev));

    task automatic wrap_up();
        if (failures == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= {idx, 2'b00};
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the read edge.
    task automatic rchk(input logic [7:0] idx, input logic [31:0] e, input string m);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= {idx, 2'b00};
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        `CHK(regRdData, e, m)
    endtask

    task automatic waitHi(input bit sel, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            if ((sel ? motorHalt : currentReduce) === 1'b1) return;
        end
        failures++;
        wrap_up();
    endtask

    task automatic tReset();
        `CHK(fullSteps, 16'h00c8, "fullSteps reset")
        `CHK(unitSelect, 1'b1, "unit reset")
        rchk(IDX_FULLSTEPS, 32'h0000_00c8, "fullsteps reg");
        rchk(IDX_PWR_DELAY, 32'h0000_00c8, "delay reg");
        rchk(IDX_UNIT, 32'h0000_0001, "unit reg");
    endtask

    task automatic tSettings();
        wr(IDX_FULLSTEPS, 32'h0000_ffff);
        wr(IDX_ENC_RES, 32'h0000_1000);
        wr(IDX_UNIT, 32'h0000_0000);
        wr(IDX_DIR_INV, 32'h0000_0001);
        dirIn <= 1'b1;
        cyc(2);
        #1;
        `CHK(fullSteps, 16'hffff, "fullSteps")
        `CHK(encCountsPerRev, 16'h1000, "enc res")
        `CHK(unitSelect, 1'b0, "unit")
        `CHK(dirOut, 1'b0, "invert")
        rchk(IDX_ENC_RES, 32'h0000_1000, "enc res reg");
        rchk(8'hc8, 32'h0000_0000, "unmapped");
    endtask

    task automatic tIndex();
        wr(IDX_ENC_COUNT, 32'h0000_1234);
        actualPos <= 32'h8000_0000;
        wr(IDX_ENC_MODE, 32'h0000_001c);
        rchk(IDX_ENC_COUNT, 32'h0000_1234, "enc load");
        u_quad_encoder_model.indexPulse();
        cyc(4);
        rchk(IDX_LATCH_ACT, 32'h8000_0000, "latch act");
        rchk(IDX_LATCH_ENC, 32'h0000_1234, "latch enc");
        wr(IDX_ENC_MODE, 32'h0000_011c);
        actualPos <= 32'h7fff_ffff;
        u_quad_encoder_model.indexPulse();
        cyc(4);
        rchk(IDX_LATCH_ACT, 32'h7fff_ffff, "latch again");
        rchk(IDX_ENC_COUNT, 32'h0000_0000, "enc clear");
        wr(IDX_ENC_MODE, 32'h0000_0015);
        actualPos <= 32'h0000_0005;
        u_quad_encoder_model.indexPulse();
        cyc(4);
        rchk(IDX_LATCH_ACT, 32'h7fff_ffff, "ab mismatch");
        u_quad_encoder_model.stepUp();
        u_quad_encoder_model.indexPulse();
        cyc(4);
        rchk(IDX_LATCH_ACT, 32'h0000_0005, "ab match");
        wr(IDX_ENC_MODE, 32'h0000_002c);
        actualPos <= 32'h0000_0006;
        u_quad_encoder_model.indexPulse();
        cyc(4);
        actualPos <= 32'h0000_0007;
        rchk(IDX_LATCH_ACT, 32'h0000_0006, "single shot");
        u_quad_encoder_model.indexPulse();
        cyc(4);
        rchk(IDX_LATCH_ACT, 32'h0000_0006, "disarmed");
    endtask

    task automatic tStatus();
        cyc(1);
        loadValue <= 10'h3ff;
        {overTemp, tempWarn, shortA, shortB, coilPolA, coilPolB} <= 6'h3f;
        cyc(20);
        wr(IDX_LOAD, 32'h0000_0000);
        rchk(IDX_DRV_STATUS, 32'h0000_00fe, "status set");
        rchk(IDX_LOAD, 32'h0000_03ff, "load");
        cyc(1);
        {overTemp, tempWarn, shortA, shortB} <= 4'h0;
        chopA <= 1'b1;
        cyc(1);
        chopA <= 1'b0;
        coilPolA <= 1'b0;
        rchk(IDX_DRV_STATUS, 32'h0000_00c0, "status clear");
        cyc(1);
        stallDetect <= 1'b1;
        rchk(IDX_DRV_STATUS, 32'h0000_00c1, "stall bit");
        cyc(1);
        stallDetect <= 1'b0;
        wr(IDX_MAX_DEV, 32'h0000_000a);
        actualPos <= 32'h0000_0040;
        waitHi(1'b1, 20);
        wr(IDX_MAX_DEV, 32'h0000_0000);
        cyc(2);
        #1;
        `CHK(motorHalt, 1'b0, "deviation off")
        rchk(IDX_EXT_FAULT, 32'h0000_0003, "ext flags");
        rchk(IDX_EXT_FAULT, 32'h0000_0000, "read clears");
        cyc(1);
        stallDetect <= 1'b1;
        cyc(1);
        stallDetect <= 1'b0;
        localCmdValid <= 1'b1;
        localCmd <= MOTOR_HALT_CMD;
        cyc(1);
        localCmdValid <= 1'b0;
        cyc(3);
        rchk(IDX_EXT_FAULT, 32'h0000_0000, "command clears");
    endtask

    task automatic tGroup();
        wr(IDX_GROUP, 32'h0000_0003);
        for (int i = 0; i < 5; i++) begin
            peerCmdValid <= 1'b1;
            peerCmdGroup <= 8'h03;
            peerCmd <= motion_cmd_t'(i);
            cyc(1);
            peerCmdValid <= 1'b0;
            #1;
            `CHK(applyValid, 1'b1, "peer apply")
            `CHK(applyCmd, motion_cmd_t'(i), "peer cmd")
            cyc(1);
        end
        peerCmdValid <= 1'b1;
        peerCmdGroup <= 8'h05;
        cyc(1);
        peerCmdValid <= 1'b0;
        localCmdValid <= 1'b1;
        localCmd <= ROTATE_RIGHT_CMD;
        #1;
        `CHK(applyValid, 1'b0, "other group")
        cyc(1);
        localCmdValid <= 1'b0;
        #1;
        `CHK(groupOutValid, 1'b1, "fan out")
        `CHK(groupOutIndex, 8'h03, "fan out group")
        `CHK(groupOutCmd, ROTATE_RIGHT_CMD, "fan out cmd")
        `CHK(applyValid, 1'b1, "local apply")
        `CHK(applyCmd, ROTATE_RIGHT_CMD, "local apply cmd")
    endtask

    task automatic tPower();
        cyc(1);
        standbyZero <= 1'b1;
        wr(IDX_PWR_DELAY, 32'h0000_0001);
        for (int m = 0; m < 4; m++) begin
            wr(IDX_IDLE_COIL, 32'(m));
            stepPulse <= 1'b1;
            cyc(1);
            stepPulse <= 1'b0;
            rchk(IDX_DRV_STATUS, 32'h0000_0040, "moving");
            `CHK(currentReduce, 1'b0, "no reduce")
            waitHi(1'b0, 40);
            cyc(1);
            #1;
            `CHK(coilMode, 2'(m), "idle coil")
        end
        cyc(1);
        standbyZero <= 1'b0;
        cyc(2);
        #1;
        `CHK(coilMode, 2'h0, "standby not zero")
    endtask

    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        tReset();
        tSettings();
        tIndex();
        tStatus();
        tGroup();
        tPower();
        wrap_up();
    end
endmodule
